// ---- common/wrtc_pkg.sv ----
// Constants for the watch-style real-time clock block
//
// Overview of operation
// - Timekeeping runs from an external 32.768 kHz crystal clock, not the core clock.
// - A prescaler divides the crystal clock down to a 1 Hz second tick.
// - Time is held in 6-bit seconds, 6-bit minutes, 5-bit hours, 8-bit days.
// - Software may enable periodic interrupts on each second, minute or day tick.
// - An enabled alarm interrupts when the running time equals its programmed value.
// - Two alarms: one matches time of day, one matches day and time.
// - Stopwatch loads a programmed value and counts down per minute while enabled.
// - An enabled stopwatch raises an interrupt when its countdown underflows.
// - Every interrupt cause can wake the processor from low power.
// - Counting never pauses for processor power states.
package wrtc_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned XTAL_HZ = 32768;
    localparam int unsigned TICK_HZ = 1;
    localparam int unsigned DIV_COUNT = XTAL_HZ / TICK_HZ;
    localparam int unsigned SW_WIDTH = 16;
    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] TIME_OFF = 8'h00;
    localparam logic [7:0] CTRL_OFF = 8'h04;
    localparam logic [7:0] STAT_OFF = 8'h08;
    localparam logic [7:0] ALM0_OFF = 8'h0C;
    localparam logic [7:0] ALM1_OFF = 8'h10;
    localparam logic [7:0] SWCH_OFF = 8'h14;
    // ----------------------------------------
    // Time word layout and limits
    // ----------------------------------------
    localparam int SEC_LSB = 0;
    localparam int MIN_LSB = 8;
    localparam int HOUR_LSB = 16;
    localparam int DAY_LSB = 24;
    localparam logic [5:0] SEC_MAX = 6'h3B;
    localparam logic [5:0] MIN_MAX = 6'h3B;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [31:0] TOD_MASK = 32'h001F_3F3F;
    localparam logic [31:0] DAYT_MASK = 32'hFF1F_3F3F;
    // ----------------------------------------
    // Event bits: same position in control and status
    // ----------------------------------------
    localparam int EV_SEC = 0;
    localparam int EV_MIN = 1;
    localparam int EV_DAY = 2;
    localparam int EV_ALM0 = 3;
    localparam int EV_ALM1 = 4;
    localparam int EV_SW = 5;
    localparam int N_EV = 6;
    localparam logic [N_EV-1:0] CTRL_RST = 6'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage : wrtc_pkg

// ---- common/wrtc_if.sv ----
// Tick and stopwatch signals shared inside the real-time clock
`timescale 1ns/1ps
interface wrtc_if #(parameter int SW_W = 16);
    logic sec_tick;
    logic min_tick;
    logic sw_load;
    logic sw_en;
    logic sw_under;
    logic [SW_W-1:0] sw_value;
    logic [SW_W-1:0] sw_count;
    modport ctl (input sec_tick, sw_count, sw_under, output min_tick, sw_load, sw_en, sw_value);
    modport pre (output sec_tick);
    modport sw (input min_tick, sw_load, sw_en, sw_value, output sw_count, sw_under);
endinterface : wrtc_if

// ---- rtl/wrtc_prescale.sv ----
// Crystal edge counter producing the one-second tick
`timescale 1ns/1ps
module wrtc_prescale import wrtc_pkg::*; #(
    parameter int unsigned DIV = DIV_COUNT
) (
    input wire logic clk_in,  // System clock
    input wire logic srst_in, // Synchronous reset
    input wire logic xtal_in, // Crystal clock level
    wrtc_if.pre tk            // Tick out
);
    localparam int DW = $clog2(DIV);
    localparam logic [DW-1:0] LAST = DW'(DIV - 1);
    logic xtal_reg;
    logic [DW-1:0] div_reg;
    logic tick_reg;
    logic rise;

    assign rise = xtal_in & ~xtal_reg;
    assign tk.sec_tick = tick_reg;

    always_ff @(posedge clk_in) begin
        // Tracks the pin through reset, so a high crystal at release is no edge
        xtal_reg <= xtal_in;
    end

    // Count crystal rising edges, never gated by power state
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            div_reg <= '0;
        end else if (rise) begin
            div_reg <= (div_reg == LAST) ? '0 : div_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        tick_reg <= !srst_in && rise && (div_reg == LAST);
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    tick_cause_a: assert property (tick_reg |-> $past(rise) && $past(div_reg) == LAST)
        else $error("Second tick without full crystal count");
    tick_due_a: assert property (rise && div_reg == LAST |=> tick_reg ##1 !tick_reg)
        else $error("Crystal count complete but no single tick");
    tick_seen_c: cover property (tick_reg);
endmodule : wrtc_prescale

// ---- rtl/wrtc_stopwatch.sv ----
// Minute-resolution countdown stopwatch
`timescale 1ns/1ps
module wrtc_stopwatch #(
    parameter int SW_W = 16
) (
    input wire logic clk_in,  // System clock
    input wire logic srst_in, // Synchronous reset
    wrtc_if.sw sw             // Control and count
);
    logic [SW_W-1:0] count_reg;
    logic under_reg;

    assign sw.sw_count = count_reg;
    assign sw.sw_under = under_reg;

    // Load wins over a minute tick in the same cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count_reg <= '0;
        end else if (sw.sw_load) begin
            count_reg <= sw.sw_value;
        end else if (sw.sw_en && sw.min_tick) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        under_reg <= !srst_in && !sw.sw_load && sw.sw_en && sw.min_tick && (count_reg == '0);
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sw_decrement_a: assert property (!sw.sw_load && sw.sw_en && sw.min_tick
        |=> count_reg == $past(count_reg) - 1'b1)
        else $error("Stopwatch did not count down");
    sw_underflow_a: assert property (under_reg |-> $past(count_reg) == '0 && $past(sw.sw_en))
        else $error("Underflow flagged with nonzero count");
    sw_hold_a: assert property (!sw.sw_load && !sw.sw_en |=> $stable(count_reg))
        else $error("Disabled stopwatch changed");
    sw_under_c: cover property (under_reg);
endmodule : wrtc_stopwatch

// ---- rtl/wrtc_top.sv ----
// Real-time clock: time counters, alarms, flags and register port
`timescale 1ns/1ps
module wrtc_top import wrtc_pkg::*; #(
    parameter int unsigned DIV = DIV_COUNT,
    parameter int SW_W = SW_WIDTH
) (
    input wire logic clk_in,          // 200 MHz clock
    input wire logic srst_in,         // Synchronous reset
    input wire logic xtal_in,         // 32.768 kHz crystal level
    input wire logic [7:0] addr_in,   // Register byte address
    input wire logic [31:0] wdata_in, // Write data
    input wire logic wr_in,           // Write strobe
    input wire logic rd_in,           // Read strobe
    output logic [31:0] rdata_out,    // Read data, cycle after strobe
    output logic irq_out              // Interrupt and wake request
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    wrtc_if #(.SW_W(SW_W)) tk ();
    logic [5:0] sec_reg;
    logic [5:0] min_reg;
    logic [4:0] hour_reg;
    logic [7:0] day_reg;
    logic [N_EV-1:0] ctrl_reg;
    logic [N_EV-1:0] stat_reg;
    logic [N_EV-1:0] stat_next;
    logic [N_EV-1:0] ev;
    logic [31:0] alm0_reg;
    logic [31:0] alm1_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    logic tick_d_reg;
    logic min_d_reg;
    logic day_d_reg;
    logic tick;
    logic min_evt;
    logic hour_evt;
    logic day_evt;
    logic time_wr;
    logic [31:0] now;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic stb);
        hit = stb && (a == off);
    endfunction : hit

    function automatic logic [31:0] pack_time(input logic [5:0] s, input logic [5:0] m,
                                              input logic [4:0] h, input logic [7:0] d);
        pack_time = {d, 3'h0, h, 2'h0, m, 2'h0, s};
    endfunction : pack_time

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    wrtc_prescale #(.DIV(DIV)) u_pre (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .xtal_in(xtal_in),
        .tk(tk.pre)
    );

    wrtc_stopwatch #(.SW_W(SW_W)) u_sw (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .sw(tk.sw)
    );

    // ----------------------------------------
    // Time counters
    // ----------------------------------------
    assign tick = tk.sec_tick;
    assign min_evt = tick && (sec_reg >= SEC_MAX);
    assign hour_evt = min_evt && (min_reg >= MIN_MAX);
    assign day_evt = hour_evt && (hour_reg >= HOUR_MAX);
    assign time_wr = hit(addr_in, TIME_OFF, wr_in);
    assign now = pack_time(sec_reg, min_reg, hour_reg, day_reg);

    // A software load wins over a tick in the same cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sec_reg <= '0;
            min_reg <= '0;
            hour_reg <= '0;
            day_reg <= '0;
        end else if (time_wr) begin
            sec_reg <= wdata_in[SEC_LSB +: 6];
            min_reg <= wdata_in[MIN_LSB +: 6];
            hour_reg <= wdata_in[HOUR_LSB +: 5];
            day_reg <= wdata_in[DAY_LSB +: 8];
        end else if (tick) begin
            sec_reg <= min_evt ? '0 : sec_reg + 1'b1;
            if (min_evt) begin
                min_reg <= hour_evt ? '0 : min_reg + 1'b1;
            end
            if (hour_evt) begin
                hour_reg <= day_evt ? '0 : hour_reg + 1'b1;
            end
            if (day_evt) begin
                day_reg <= day_reg + 1'b1;
            end
        end
    end

    // Events are judged one cycle late, against the updated counters
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tick_d_reg <= 1'b0;
            min_d_reg <= 1'b0;
            day_d_reg <= 1'b0;
        end else begin
            tick_d_reg <= tick && !time_wr;
            min_d_reg <= min_evt && !time_wr;
            day_d_reg <= day_evt && !time_wr;
        end
    end

    // ----------------------------------------
    // Stopwatch control
    // ----------------------------------------
    assign tk.min_tick = min_d_reg;
    assign tk.sw_load = hit(addr_in, SWCH_OFF, wr_in);
    assign tk.sw_value = wdata_in[SW_W-1:0];
    assign tk.sw_en = ctrl_reg[EV_SW];

    // ----------------------------------------
    // Control and alarm registers
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_reg <= CTRL_RST;
        end else if (hit(addr_in, CTRL_OFF, wr_in)) begin
            ctrl_reg <= wdata_in[N_EV-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            alm0_reg <= WORD_RST;
            alm1_reg <= WORD_RST;
        end else begin
            if (hit(addr_in, ALM0_OFF, wr_in)) begin
                alm0_reg <= wdata_in & TOD_MASK;
            end
            if (hit(addr_in, ALM1_OFF, wr_in)) begin
                alm1_reg <= wdata_in & DAYT_MASK;
            end
        end
    end

    // ----------------------------------------
    // Event flags
    // ----------------------------------------
    always_comb begin
        ev = '0;
        ev[EV_SEC] = tick_d_reg && ctrl_reg[EV_SEC];
        ev[EV_MIN] = min_d_reg && ctrl_reg[EV_MIN];
        ev[EV_DAY] = day_d_reg && ctrl_reg[EV_DAY];
        ev[EV_ALM0] = tick_d_reg && ctrl_reg[EV_ALM0] && ((now & TOD_MASK) == alm0_reg);
        ev[EV_ALM1] = tick_d_reg && ctrl_reg[EV_ALM1] && (now == alm1_reg);
        ev[EV_SW] = tk.sw_under;
    end

    // Write one to clear; a new event in the clearing cycle survives
    always_comb begin
        stat_next = stat_reg | ev;
        if (hit(addr_in, STAT_OFF, wr_in)) begin
            stat_next = (stat_reg & ~wdata_in[N_EV-1:0]) | ev;
        end
    end

    always_ff @(posedge clk_in) begin
        stat_reg <= srst_in ? '0 : stat_next;
    end

    // Any pending flag requests service and wake
    always_ff @(posedge clk_in) begin
        irq_reg <= !srst_in && (|stat_next);
    end

    assign irq_out = irq_reg;

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in || !rd_in) begin
            rdata_reg <= '0;
        end else begin
            unique case (addr_in)
                TIME_OFF: rdata_reg <= now;
                CTRL_OFF: rdata_reg <= {{(32-N_EV){1'b0}}, ctrl_reg};
                STAT_OFF: rdata_reg <= {{(32-N_EV){1'b0}}, stat_reg};
                ALM0_OFF: rdata_reg <= alm0_reg;
                ALM1_OFF: rdata_reg <= alm1_reg;
                SWCH_OFF: rdata_reg <= {{(32-SW_W){1'b0}}, tk.sw_count};
                default: rdata_reg <= '0;
            endcase
        end
    end

    assign rdata_out = rdata_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sec_count_a: assert property (tick && !time_wr && sec_reg < SEC_MAX
        |=> sec_reg == $past(sec_reg) + 1'b1 && $stable(min_reg))
        else $error("Seconds did not advance on tick");
    minute_carry_a: assert property (tick && !time_wr && sec_reg == SEC_MAX && min_reg < MIN_MAX
        |=> sec_reg == 0 && min_reg == $past(min_reg) + 1'b1)
        else $error("Seconds wrap did not carry");
    day_carry_a: assert property (tick && !time_wr && day_evt
        |=> hour_reg == 0 && min_reg == 0 && day_reg == $past(day_reg) + 1'b1)
        else $error("Hour wrap did not carry to day");
    no_tick_hold_a: assert property (!tick && !time_wr |=> $stable(now))
        else $error("Time moved without a tick");
    minute_flag_a: assert property (min_evt && !time_wr && ctrl_reg[EV_MIN] && !hit(addr_in, CTRL_OFF, wr_in)
        |=> ##1 stat_reg[EV_MIN] ##1 irq_out)
        else $error("Minute interrupt missing");
    alarm0_flag_a: assert property (tick_d_reg && ctrl_reg[EV_ALM0] && (now & TOD_MASK) == alm0_reg
        |=> stat_reg[EV_ALM0])
        else $error("Time of day alarm missed");
    alarm1_flag_a: assert property (stat_reg[EV_ALM1] && !$past(stat_reg[EV_ALM1])
        |-> $past(ctrl_reg[EV_ALM1]) && $past(now) == $past(alm1_reg))
        else $error("Day alarm flag without match");
    flag_sticky_a: assert property (stat_reg[EV_SW] && !hit(addr_in, STAT_OFF, wr_in)
        |=> stat_reg[EV_SW])
        else $error("Stopwatch flag dropped without clear");
    sw_flag_a: assert property (tk.sw_under |=> stat_reg[EV_SW])
        else $error("Stopwatch underflow not latched");
    irq_level_a: assert property (irq_out == (|stat_reg))
        else $error("Interrupt output disagrees with flags");
    read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 0)
        else $error("Read data outside read slot");

    day_wrap_c: cover property (day_evt);
    alarm1_c: cover property (ev[EV_ALM1]);
    clear_race_c: cover property (hit(addr_in, STAT_OFF, wr_in) && |ev);
endmodule : wrtc_top

// ---- tb/wrtc_xtal.sv ----
// Behavioural crystal source for the real-time clock bench
`timescale 1ns/1ps
module wrtc_xtal #(
    parameter int HALF = 2
) (
    input wire logic clk_in,  // Bench clock
    input wire logic slow_in, // Double the half period
    output logic xtal_out     // Crystal level
);
    int cnt = 0;
    initial xtal_out = 1'b0;
    // ----------------------------------------
    // Free-running oscillator
    // ----------------------------------------
    // Never stops, even in reset: the real crystal ignores the core's state
    always @(posedge clk_in) begin
        if (cnt >= (slow_in ? 2 * HALF : HALF) - 1) begin
            cnt <= 0;
            xtal_out <= ~xtal_out;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : wrtc_xtal

// ---- tb/testbench.sv ----
// Self-checking bench for the real-time clock top
`timescale 1ns/1ps
module testbench import wrtc_pkg::*;;
    localparam int SIM_DIV = 4;
    localparam int XHALF = 2;
    localparam int SEC_CYC = SIM_DIV * 2 * XHALF;
    logic clk_in, srst_in, xtal, slow, wr, rd, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, t;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    wrtc_xtal #(.HALF(XHALF)) xtal_model (.clk_in(clk_in), .slow_in(slow), .xtal_out(xtal));
    wrtc_top #(.DIV(SIM_DIV), .SW_W(SW_WIDTH)) DUT (.clk_in(clk_in), .srst_in(srst_in), .xtal_in(xtal),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq));
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (num_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_read
    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus_read(a, d);
        check(d, exp);
    endtask : read_check
    // Looks just after each edge, once the registered output has settled
    task automatic wait_irq(input int lim);
        for (int i = 0; i < lim && irq !== 1'b1; i++) begin
            @(posedge clk_in);
            #1;
        end
        check({31'h0, irq}, 32'h1);
    endtask : wait_irq
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : idle
    // Polls every other cycle, so change times land on a fixed phase
    task automatic wait_change(input logic [7:0] a, input logic [31:0] old, output logic [31:0] now);
        now = old;
        for (int i = 0; i < 200 && now === old; i++) bus_read(a, now);
    endtask : wait_change
    task automatic clear_all();
        bus_write(CTRL_OFF, 32'h0000_0000);
        bus_write(STAT_OFF, 32'h0000_003F);
        read_check(STAT_OFF, 32'h0000_0000);
        check({31'h0, irq}, 32'h0);
    endtask : clear_all
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset_map();
        logic [7:0] offs [6];
        offs = '{TIME_OFF, CTRL_OFF, STAT_OFF, ALM0_OFF, ALM1_OFF, SWCH_OFF};
        for (int i = 0; i < 6; i++) read_check(offs[i], 32'h0000_0000);
        bus_write(8'h18, 32'hFFFF_FFFF);
        read_check(8'h18, 32'h0000_0000);
        bus_write(CTRL_OFF, 32'hFFFF_FFC0);
        read_check(CTRL_OFF, 32'h0000_0000);
        bus_write(ALM0_OFF, 32'hFFFF_FFFF);
        read_check(ALM0_OFF, TOD_MASK);
        bus_write(ALM1_OFF, 32'hFFFF_FFFF);
        read_check(ALM1_OFF, DAYT_MASK);
    endtask : test_reset_map
    task automatic test_rate(input logic s, input int exp_cyc);
        int c0;
        slow <= s;
        bus_read(TIME_OFF, t);
        wait_change(TIME_OFF, t, t);
        wait_change(TIME_OFF, t, t);
        c0 = cyc;
        wait_change(TIME_OFF, t, t);
        check(32'(cyc - c0), 32'(exp_cyc));
    endtask : test_rate
    task automatic test_wrap();
        bus_write(TIME_OFF, 32'hFF17_3B3A);
        wait_change(TIME_OFF, 32'hFF17_3B3A, t);
        check(t, 32'hFF17_3B3B);
        wait_change(TIME_OFF, t, t);
        check(t, 32'h0000_0000);
    endtask : test_wrap
    task automatic test_periodic();
        bus_write(CTRL_OFF, 32'h0000_0001);
        wait_irq(2 * SEC_CYC + 4);
        idle(2 * SEC_CYC);
        check({31'h0, irq}, 32'h1);
        read_check(STAT_OFF, 32'h0000_0001);
        clear_all();
        idle(3 * SEC_CYC);
        check({31'h0, irq}, 32'h0);
        bus_write(CTRL_OFF, 32'h0000_0006);
        bus_write(TIME_OFF, 32'h0017_3B3B);
        wait_irq(2 * SEC_CYC + 4);
        read_check(STAT_OFF, 32'h0000_0006);
        read_check(TIME_OFF, 32'h0100_0000);
        clear_all();
    endtask : test_periodic
    task automatic test_alarm();
        bus_write(ALM0_OFF, 32'h0000_0003);
        bus_write(ALM1_OFF, 32'h0200_0005);
        bus_write(TIME_OFF, 32'h0100_0000);
        bus_write(CTRL_OFF, 32'h0000_0018);
        wait_irq(4 * SEC_CYC + 8);
        read_check(STAT_OFF, 32'h0000_0008);
        read_check(TIME_OFF, 32'h0100_0003);
        bus_write(STAT_OFF, 32'h0000_0008);
        // Day 1 passes 00:00:05, so the day-qualified alarm must stay quiet
        idle(3 * SEC_CYC);
        check({31'h0, irq}, 32'h0);
        bus_write(TIME_OFF, 32'h0200_0004);
        wait_irq(2 * SEC_CYC + 4);
        read_check(STAT_OFF, 32'h0000_0010);
        read_check(TIME_OFF, 32'h0200_0005);
        clear_all();
    endtask : test_alarm
    task automatic test_stopwatch();
        bus_write(SWCH_OFF, 32'h0000_0001);
        bus_write(TIME_OFF, 32'h0000_003B);
        idle(2 * SEC_CYC);
        read_check(SWCH_OFF, 32'h0000_0001);
        bus_write(CTRL_OFF, 32'h0000_0020);
        bus_write(TIME_OFF, 32'h0000_003B);
        wait_change(SWCH_OFF, 32'h0000_0001, t);
        check(t, 32'h0000_0000);
        check({31'h0, irq}, 32'h0);
        bus_write(TIME_OFF, 32'h0000_003B);
        wait_irq(2 * SEC_CYC + 6);
        read_check(STAT_OFF, 32'h0000_0020);
        read_check(SWCH_OFF, 32'h0000_FFFF);
        clear_all();
    endtask : test_stopwatch
    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        srst_in = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        slow = 1'b0;
        repeat (8) @(posedge clk_in);
        srst_in <= 1'b0;
        check({31'h0, irq}, 32'h0);
        test_reset_map();
        test_rate(1'b0, SEC_CYC);
        test_rate(1'b1, 2 * SEC_CYC);
        slow <= 1'b0;
        test_wrap();
        test_periodic();
        test_alarm();
        test_stopwatch();
        tally_and_finish();
    end
endmodule : testbench
